// *** osp_adc_model.sv ***
// Conversion source and sample sink facing the block
`timescale 1ns/10ps
module osp_adc_model (
    input  wire logic                    clk_i,
    input  wire logic                    stall_i,
    input  wire logic                    conv_ready_i,
    output logic                         conv_valid_o,
    output osp_pkg::osp_conv_type        conv_o,
    input  wire logic                    out_valid_i,
    input  wire osp_pkg::osp_sample_type out_sample_i,
    output logic                         out_ready_o
);
    import osp_pkg::*;
    osp_conv_type   pend_q[$];
    osp_sample_type got_q[$];
    logic           hold;
    initial begin
        conv_valid_o = 1'b0;
        conv_o = '0;
        out_ready_o = 1'b1;
    end
    task put(input logic [3:0] m, input logic c, input logic a, input logic [19:0] d);
        pend_q.push_back('{meas: m, chan: c, ambient: a, data: d});
    endtask
    always @(posedge clk_i) begin
        hold = stall_i;
        if (conv_valid_o && conv_ready_i) void'(pend_q.pop_front());
        if (out_valid_i && out_ready_o) got_q.push_back(out_sample_i);
        #1;
        out_ready_o = !hold;
        conv_valid_o = pend_q.size() > 0;
        conv_o = conv_valid_o ? pend_q[0] : osp_conv_type'(~conv_o);
    end
endmodule

// *** osp_defs.svh ***
// Register offsets, field positions, reset values and scaling constants
`ifndef OSP_DEFS_SVH
`define OSP_DEFS_SVH

`define OSP_ADDR_STATUS     8'h00
`define OSP_ADDR_CANCEL_LO  8'h20
`define OSP_ADDR_CANCEL_HI  8'h21
`define OSP_ADDR_DET_MEAS   8'h68
`define OSP_ADDR_HYST       8'h69
`define OSP_ADDR_D1_UPPER   8'h6A
`define OSP_ADDR_D1_LOWER   8'h6B
`define OSP_ADDR_D2_UPPER   8'h6C
`define OSP_ADDR_D2_LOWER   8'h6D
`define OSP_ADDR_PF_SEL     8'h70
`define OSP_ADDR_PF_CFG     8'h71
`define OSP_ADDR_IRQ1_EN    8'h78
`define OSP_ADDR_IRQ2_EN    8'h7C

`define OSP_HYST_LEVEL_LSB  0
`define OSP_HYST_TIME_LSB   3
`define OSP_HYST_D1_CHSEL   6
`define OSP_HYST_D2_CHSEL   7
`define OSP_PF_MEAS_LSB     0
`define OSP_PF_CH1_BIT      6
`define OSP_PF_CH2_BIT      7
`define OSP_PF_MULT_LSB     0
`define OSP_PF_INIT_LSB     2
`define OSP_PF_TC_LSB       4
`define OSP_PREDICTION_ORDER_BIT    6
`define OSP_DET1_BIT        0
`define OSP_DET2_BIT        1

`define OSP_REG_RESET       8'h00
`define OSP_LPF_INIT_BASE   20'h00010
`define OSP_TC_BASE_SHIFT   3
`define OSP_MULT_BASE_SHIFT 2
`define OSP_LIMIT_SHIFT     12
`define OSP_LVL_SHIFT       9
`define OSP_PF_PRIMED       3'h4

`endif

// *** osp_pkg.sv ***
// Types shared by the optical sample post-processing block
package osp_pkg;

    typedef struct packed {
        logic [3:0]  meas;
        logic        chan;
        logic        ambient;
        logic [19:0] data;
    } osp_conv_type;

    typedef struct packed {
        logic [3:0]  meas;
        logic        chan;
        logic [19:0] data;
    } osp_sample_type;

    typedef enum logic [1:0] {
        PH_IDLE,
        PH_AMB,
        PH_EXP
    } osp_phase_type;

endpackage

// *** osp_postprocess.sv ***
// Ambient cancellation, threshold detectors and outlier replacement
`timescale 1ns/10ps
`include "osp_defs.svh"

// Overview of operation
// R1: Three-conversion mode: two ambient plus one exposure conversion per measurement.
// R2: Two-conversion mode: one ambient plus one exposure conversion per measurement.
// R3: Each measurement picks its cancellation method from its own select bit.
// R4: Only the final effective exposure value goes to the output stream.
// R5: Output exposure minus ambient, or exposure minus mean of both ambients.
// R6: Two detectors, off after reset, each enabled by its bit in either enable register.
// R7: Each detector watches channel one or two per its channel-select bit.
// R8: Each detector compares samples to programmable upper and lower limits.
// R9: Two-bit time hysteresis and three-bit level hysteresis qualify crossings.
// R10: Enabled detector sets its status bit after a qualified crossing.
// R11: Outlier replacement enabled per measurement and per channel via select register.
// R12: Outlier replacement disabled everywhere after reset.
// R13: Absolute error against prediction above threshold marks an outlier.
// R14: Order bit zero predicts the previous converted value.
// R15: Order bit one predicts by least-squares line through four past outputs.
// R16: Threshold is filtered error times 4, 8, 16 or 32.
// R17: Error filter is recursive with time constant 8 to 64 samples.
// R18: Filter state loads the selected initial value on initialisation.
// R19: Outliers are replaced by the prediction, others pass unchanged.
// R20: Software should keep defaults but set the multiplier field to 32x.
// R21: History and filter state kept per measurement and channel.
module osp_postprocess
    import osp_pkg::*;
#(
    parameter int NUM_MEAS = 9
) (
    input  wire logic                   clk_i,
    input  wire logic                   nrst_i,
    input  wire logic                   conv_valid_i,
    input  wire osp_pkg::osp_conv_type  conv_i,
    output logic                        conv_ready_o,
    output logic                        out_valid_o,
    output osp_pkg::osp_sample_type     out_sample_o,
    input  wire logic                   out_ready_i,
    input  wire logic                   reg_wr_i,
    input  wire logic                   reg_rd_i,
    input  wire logic [7:0]             reg_addr_i,
    input  wire logic [7:0]             reg_wdata_i,
    output logic [7:0]                  reg_rdata_o
);
    import osp_pkg::*;

    localparam int SLOTS = 2 * NUM_MEAS;

    if (NUM_MEAS < 1 || NUM_MEAS > 15) begin : gen_bad_meas
        $error("NUM_MEAS must be 1 to 15");
    end

    function automatic logic [4:0] slot_of(input logic [3:0] meas, input logic chan);
        slot_of = 5'({meas - 4'h1, chan});
    endfunction

    // Configuration and status registers
    logic [7:0] status_reg;
    logic [7:0] cancel_lo_reg;
    logic [7:0] cancel_hi_reg;
    logic [7:0] det_meas_reg;
    logic [7:0] hyst_reg;
    logic [7:0] limit_reg [4];
    logic [7:0] pf_sel_reg;
    logic [7:0] pf_cfg_reg;
    logic [7:0] irq1_en_reg;
    logic [7:0] irq2_en_reg;

    // Per-slot cancellation and outlier state
    osp_phase_type phase_reg [SLOTS];
    logic [19:0]   amb_reg   [SLOTS];
    logic [19:0]   exp_reg   [SLOTS];
    logic [19:0]   hist_reg  [SLOTS][4];
    logic [2:0]    cnt_reg   [SLOTS];
    logic [19:0]   lpf_reg   [SLOTS];

    osp_phase_type phase_next;
    logic          emit;
    logic [20:0]   cancel_val;

    wire        buf_in_ready;
    wire        accept   = conv_valid_i && conv_ready_o;
    wire [4:0]  slot     = slot_of(conv_i.meas, conv_i.chan);
    wire [15:0] cancel_sel = {cancel_hi_reg, cancel_lo_reg};
    // R3: per-measurement method
    wire        three_conv = cancel_sel[4'(conv_i.meas - 4'h1)];
    wire [20:0] amb_mean   = 21'(({1'b0, amb_reg[slot]} + {1'b0, conv_i.data}) >> 1);

    // R1 R2: conversion sequencing per slot
    always_comb begin
        phase_next = phase_reg[slot];
        emit       = 1'b0;
        cancel_val = '0;
        case (phase_reg[slot])
            PH_IDLE: begin
                if (conv_i.ambient) begin
                    phase_next = PH_AMB;
                end
            end
            PH_AMB: begin
                if (!conv_i.ambient) begin
                    phase_next = three_conv ? PH_EXP : PH_IDLE;
                    emit       = !three_conv;
                    cancel_val = {1'b0, conv_i.data} - {1'b0, amb_reg[slot]};
                end
            end
            PH_EXP: begin
                phase_next = PH_IDLE;
                emit       = conv_i.ambient;
                cancel_val = {1'b0, exp_reg[slot]} - amb_mean;
            end
            default: begin
                phase_next = PH_IDLE;
            end
        endcase
    end

    // R5: negative differences clamp to zero
    wire [19:0] x = cancel_val[20] ? 20'h00000 : cancel_val[19:0];

    // R11 R12: outlier enable decode
    wire pf_on = (pf_sel_reg[`OSP_PF_MEAS_LSB +: 4] == conv_i.meas)
               && (conv_i.chan ? pf_sel_reg[`OSP_PF_CH2_BIT] : pf_sel_reg[`OSP_PF_CH1_BIT]);
    wire       order   = pf_cfg_reg[`OSP_PREDICTION_ORDER_BIT];
    wire [1:0] mult    = pf_cfg_reg[`OSP_PF_MULT_LSB +: 2];
    wire [1:0] init_v  = pf_cfg_reg[`OSP_PF_INIT_LSB +: 2];
    wire [1:0] tc      = pf_cfg_reg[`OSP_PF_TC_LSB +: 2];
    wire       primed  = order ? (cnt_reg[slot] >= `OSP_PF_PRIMED) : (cnt_reg[slot] != 3'h0);

    // R15: y0 + (y1 - y3)/2 is the fit through four points
    wire signed [22:0] lsq  = 23'(signed'({3'b000, hist_reg[slot][0]}))
                            + (23'(signed'({3'b000, hist_reg[slot][1]}))
                            - 23'(signed'({3'b000, hist_reg[slot][3]}))) / 23'sd2;
    wire [19:0] lsq_c = lsq[22] ? 20'h00000 : (|lsq[21:20] ? 20'hFFFFF : lsq[19:0]);
    // R14: previous value prediction
    wire [19:0] pred  = order ? lsq_c : hist_reg[slot][0];
    // R13: absolute estimation error
    wire [19:0] err   = (x > pred) ? (x - pred) : (pred - x);
    // R16: threshold scaling
    wire [25:0] thr   = 26'({6'h00, lpf_reg[slot]} << (`OSP_MULT_BASE_SHIFT + mult));
    wire        outlier = pf_on && primed && ({6'h00, err} > thr);
    // R19: replace or pass
    wire [19:0] y     = outlier ? pred : x;
    // R17: recursive low pass
    wire signed [21:0] lpf_delta = 22'(signed'({2'b00, err})) - 22'(signed'({2'b00, lpf_reg[slot]}));
    wire signed [21:0] lpf_step  = lpf_delta >>> (`OSP_TC_BASE_SHIFT + tc);
    wire [19:0] lpf_upd = 20'(22'(signed'({2'b00, lpf_reg[slot]})) + lpf_step);
    // R18: initial filter value
    wire [19:0] lpf_init = 20'(`OSP_LPF_INIT_BASE << {init_v, 1'b0});

    // R4: only the final value is pushed
    wire            push = accept && emit;
    osp_sample_type push_sample;
    assign push_sample = '{meas: conv_i.meas, chan: conv_i.chan, data: y};
    assign conv_ready_o = buf_in_ready;

    // R21: per-slot state update
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            for (int i = 0; i < SLOTS; i++) begin
                phase_reg[i] <= PH_IDLE;
                amb_reg[i]   <= '0;
                exp_reg[i]   <= '0;
                cnt_reg[i]   <= '0;
                lpf_reg[i]   <= '0;
                for (int j = 0; j < 4; j++) begin
                    hist_reg[i][j] <= '0;
                end
            end
        end else if (accept && conv_i.meas != 4'h0 && conv_i.meas <= 4'(NUM_MEAS)) begin
            phase_reg[slot] <= phase_next;
            if (conv_i.ambient && phase_reg[slot] != PH_EXP) begin
                amb_reg[slot] <= conv_i.data;
            end
            if (!conv_i.ambient) begin
                exp_reg[slot] <= conv_i.data;
            end
            if (emit) begin
                if (!pf_on) begin
                    cnt_reg[slot] <= '0;
                end else begin
                    hist_reg[slot][0] <= order ? y : x;
                    hist_reg[slot][1] <= hist_reg[slot][0];
                    hist_reg[slot][2] <= hist_reg[slot][1];
                    hist_reg[slot][3] <= hist_reg[slot][2];
                    cnt_reg[slot]     <= (cnt_reg[slot] == `OSP_PF_PRIMED) ? cnt_reg[slot] : cnt_reg[slot] + 3'h1;
                    lpf_reg[slot]     <= primed ? lpf_upd : lpf_init;
                end
            end
        end
    end

    osp_skid_buffer #(
        .WIDTH ($bits(osp_sample_type)),
        .DEPTH (2)
    ) u_buffer (
        .clk_i       (clk_i),
        .nrst_i      (nrst_i),
        .in_valid_i  (push),
        .in_data_i   (push_sample),
        .in_ready_o  (buf_in_ready),
        .out_valid_o (out_valid_o),
        .out_data_o  (out_sample_o),
        .out_ready_i (out_ready_i)
    );

    // Threshold detectors
    logic [3:0] run_reg [2];
    logic [1:0] hit;

    wire [2:0]  level_hysteresis = hyst_reg[`OSP_HYST_LEVEL_LSB +: 3];
    wire [1:0]  time_hysteresis  = hyst_reg[`OSP_HYST_TIME_LSB +: 2];
    wire [4:0]  need       = 5'h01 << time_hysteresis;
    wire signed [22:0] band = 23'(signed'({1'b0, level_hysteresis})) <<< `OSP_LVL_SHIFT;
    wire signed [22:0] xs   = 23'(signed'({3'b000, y}));

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gen_det
            wire        ch_sel = hyst_reg[g == 0 ? `OSP_HYST_D1_CHSEL : `OSP_HYST_D2_CHSEL];
            // R6: either enable register arms it
            wire        det_en = irq1_en_reg[g] || irq2_en_reg[g];
            // R7: channel select
            wire        watch  = push && det_en && conv_i.chan == ch_sel
                               && conv_i.meas == det_meas_reg[4*g +: 4];
            // R8: limits scaled to sample range
            wire signed [22:0] up = 23'(signed'({3'b000, limit_reg[2*g]})) <<< `OSP_LIMIT_SHIFT;
            wire signed [22:0] lo = 23'(signed'({3'b000, limit_reg[2*g+1]})) <<< `OSP_LIMIT_SHIFT;
            wire        outside = (xs > up) || (xs < lo);
            // R9: level hysteresis band
            wire        back_in = (xs < up - band) && (xs > lo + band);
            wire [4:0]  run_inc = {1'b0, run_reg[g]} + 5'h01;

            // R9: time hysteresis count
            always_ff @(posedge clk_i) begin
                if (!nrst_i) begin
                    run_reg[g] <= '0;
                end else if (!det_en) begin
                    run_reg[g] <= '0;
                end else if (watch && outside) begin
                    run_reg[g] <= (run_inc >= need) ? run_reg[g] : run_inc[3:0];
                end else if (watch && back_in) begin
                    run_reg[g] <= '0;
                end
            end
            // R10: qualified crossing
            assign hit[g] = watch && outside && (run_inc >= need);
        end
    endgenerate

    wire wr_status_rd = reg_rd_i && reg_addr_i == `OSP_ADDR_STATUS;
    wire [7:0] det_bits = {6'h00, hit};

    // Register writes and sticky status
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            status_reg    <= `OSP_REG_RESET;
            cancel_lo_reg <= `OSP_REG_RESET;
            cancel_hi_reg <= `OSP_REG_RESET;
            det_meas_reg  <= `OSP_REG_RESET;
            hyst_reg      <= `OSP_REG_RESET;
            pf_sel_reg    <= `OSP_REG_RESET;
            pf_cfg_reg    <= `OSP_REG_RESET;
            irq1_en_reg   <= `OSP_REG_RESET;
            irq2_en_reg   <= `OSP_REG_RESET;
            for (int i = 0; i < 4; i++) begin
                limit_reg[i] <= `OSP_REG_RESET;
            end
        end else begin
            // R10: set wins over read clear
            status_reg <= (wr_status_rd ? 8'h00 : status_reg) | det_bits;
            if (reg_wr_i) begin
                case (reg_addr_i)
                    `OSP_ADDR_CANCEL_LO: cancel_lo_reg <= reg_wdata_i;
                    `OSP_ADDR_CANCEL_HI: cancel_hi_reg <= {7'h00, reg_wdata_i[0]};
                    `OSP_ADDR_DET_MEAS:  det_meas_reg  <= reg_wdata_i;
                    `OSP_ADDR_HYST:      hyst_reg      <= reg_wdata_i & 8'hDF;
                    `OSP_ADDR_D1_UPPER:  limit_reg[0]  <= reg_wdata_i;
                    `OSP_ADDR_D1_LOWER:  limit_reg[1]  <= reg_wdata_i;
                    `OSP_ADDR_D2_UPPER:  limit_reg[2]  <= reg_wdata_i;
                    `OSP_ADDR_D2_LOWER:  limit_reg[3]  <= reg_wdata_i;
                    `OSP_ADDR_PF_SEL:    pf_sel_reg    <= reg_wdata_i & 8'hCF;
                    `OSP_ADDR_PF_CFG:    pf_cfg_reg    <= reg_wdata_i & 8'h7F;
                    `OSP_ADDR_IRQ1_EN:   irq1_en_reg   <= {6'h00, reg_wdata_i[1:0]};
                    `OSP_ADDR_IRQ2_EN:   irq2_en_reg   <= {6'h00, reg_wdata_i[1:0]};
                    default: ;
                endcase
            end
        end
    end

    // Read data mux
    logic [7:0] rd_mux;
    always_comb begin
        case (reg_addr_i)
            `OSP_ADDR_STATUS:    rd_mux = status_reg;
            `OSP_ADDR_CANCEL_LO: rd_mux = cancel_lo_reg;
            `OSP_ADDR_CANCEL_HI: rd_mux = cancel_hi_reg;
            `OSP_ADDR_DET_MEAS:  rd_mux = det_meas_reg;
            `OSP_ADDR_HYST:      rd_mux = hyst_reg;
            `OSP_ADDR_D1_UPPER:  rd_mux = limit_reg[0];
            `OSP_ADDR_D1_LOWER:  rd_mux = limit_reg[1];
            `OSP_ADDR_D2_UPPER:  rd_mux = limit_reg[2];
            `OSP_ADDR_D2_LOWER:  rd_mux = limit_reg[3];
            `OSP_ADDR_PF_SEL:    rd_mux = pf_sel_reg;
            `OSP_ADDR_PF_CFG:    rd_mux = pf_cfg_reg;
            `OSP_ADDR_IRQ1_EN:   rd_mux = irq1_en_reg;
            `OSP_ADDR_IRQ2_EN:   rd_mux = irq2_en_reg;
            default:             rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            reg_rdata_o <= rd_mux;
        end
    end
endmodule

// *** osp_postprocess_chk.sv ***
// Port-level checker for the post-processing block
`timescale 1ns/10ps
module osp_postprocess_chk #(
    parameter int NUM_MEAS = 9
) (
    input wire logic                   clk_i,
    input wire logic                   nrst_i,
    input wire logic                   conv_valid_i,
    input wire osp_pkg::osp_conv_type  conv_i,
    input wire logic                   conv_ready_o,
    input wire logic                   out_valid_o,
    input wire osp_pkg::osp_sample_type out_sample_o,
    input wire logic                   out_ready_i,
    input wire logic                   reg_wr_i,
    input wire logic                   reg_rd_i,
    input wire logic [7:0]             reg_addr_i,
    input wire logic [7:0]             reg_wdata_i,
    input wire logic [7:0]             reg_rdata_o
);
    import osp_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    a_reset_quiet: assert property (disable iff (1'b0) !nrst_i |=> !conv_ready_o && !out_valid_o && reg_rdata_o == 8'h00)
        else $error("outputs active after reset");
    a_out_hold: assert property (out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_sample_o))
        else $error("stalled sample changed");
    a_meas_range: assert property (out_valid_o |-> out_sample_o.meas != 4'h0 && out_sample_o.meas <= NUM_MEAS)
        else $error("bad measurement number");
    a_out_cause: assert property ($rose(out_valid_o) |-> $past(conv_valid_i && conv_ready_o))
        else $error("sample without conversion");
    a_stall_full: assert property (out_valid_o && !out_ready_i && !conv_ready_o |=> !conv_ready_o)
        else $error("input taken while full");
    a_rdata_hold: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
        else $error("read data changed");
    a_enable_mask: assert property (reg_rd_i && reg_addr_i == 8'h78 |=> reg_rdata_o[7:2] == 6'h00)
        else $error("enable reserved bits");
    a_hyst_mask: assert property (reg_rd_i && reg_addr_i == 8'h69 |=> !reg_rdata_o[5])
        else $error("hysteresis reserved bit");
    a_select_mask: assert property (reg_rd_i && reg_addr_i == 8'h70 |=> reg_rdata_o[5:4] == 2'h0)
        else $error("select reserved bits");
    a_config_mask: assert property (reg_rd_i && reg_addr_i == 8'h71 |=> !reg_rdata_o[7])
        else $error("filter config reserved bit");
endmodule

bind osp_postprocess osp_postprocess_chk #(.NUM_MEAS(NUM_MEAS)) u_chk (.clk_i(clk_i), .nrst_i(nrst_i),
    .conv_valid_i(conv_valid_i), .conv_i(conv_i), .conv_ready_o(conv_ready_o), .out_valid_o(out_valid_o),
    .out_sample_o(out_sample_o), .out_ready_i(out_ready_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o));

// *** osp_postprocess_tb_top.sv ***
// Self-checking bench for the post-processing block
`timescale 1ns/10ps
module osp_postprocess_tb_top;
    import osp_pkg::*;
    logic           clk_i;
    logic           nrst_i;
    logic           reg_wr_i;
    logic           reg_rd_i;
    logic [7:0]     reg_addr_i;
    logic [7:0]     reg_wdata_i;
    logic [7:0]     reg_rdata_o;
    logic           conv_valid_i;
    logic           conv_ready_o;
    logic           out_valid_o;
    logic           out_ready_i;
    logic           stall;
    osp_conv_type   conv_i;
    osp_sample_type out_sample_o;
    int             err_total;
    int             tests_run;
    logic [7:0]     reg_a [7] = '{8'h69, 8'h70, 8'h71, 8'h78, 8'h7C, 8'h01, 8'h21};
    logic [7:0]     reg_m [7] = '{8'hDF, 8'hCF, 8'h7F, 8'h03, 8'h03, 8'h00, 8'h01};

    osp_postprocess #(.NUM_MEAS(9)) dut (.clk_i(clk_i), .nrst_i(nrst_i), .conv_valid_i(conv_valid_i),
        .conv_i(conv_i), .conv_ready_o(conv_ready_o), .out_valid_o(out_valid_o), .out_sample_o(out_sample_o),
        .out_ready_i(out_ready_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o));
    osp_adc_model model (.clk_i(clk_i), .stall_i(stall), .conv_ready_i(conv_ready_o),
        .conv_valid_o(conv_valid_i), .conv_o(conv_i), .out_valid_i(out_valid_o),
        .out_sample_i(out_sample_o), .out_ready_o(out_ready_i));

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        #1 reg_wr_i = 1'b1;
        reg_addr_i = a;
        reg_wdata_i = d;
        @(posedge clk_i);
        #1 reg_wr_i = 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_i);
        #1 reg_rd_i = 1'b1;
        reg_addr_i = a;
        @(posedge clk_i);
        #1 reg_rd_i = 1'b0;
        chk("reg_rdata_o", {24'h0, reg_rdata_o}, {24'h0, e});
    endtask
    task pair(input logic [3:0] m, input logic c, input logic [19:0] a, input logic [19:0] x);
        model.put(m, c, 1'b1, a);
        model.put(m, c, 1'b0, x);
    endtask
    task take(input logic [3:0] m, input logic c, input logic [19:0] d);
        int n;
        osp_sample_type s;
        n = 0;
        s = 'x;
        while (model.got_q.size() == 0 && n < 200) begin
            @(posedge clk_i);
            n++;
        end
        if (model.got_q.size() > 0) s = model.got_q.pop_front();
        chk("out_sample_o", {7'h0, s}, {7'h0, m, c, d});
    endtask
    task end_sim();
        $display("checks %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        err_total++;
        end_sim();
    end
    initial begin
        nrst_i = 1'b0;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        reg_addr_i = 8'h00;
        reg_wdata_i = 8'h00;
        stall = 1'b0;
        err_total = 0;
        tests_run = 0;
        repeat (5) @(posedge clk_i);
        #1 nrst_i = 1'b1;
        rd(8'h00, 8'h00);
        foreach (reg_a[i]) rd(reg_a[i], 8'h00);
        foreach (reg_a[i]) begin
            wr(reg_a[i], 8'hFF);
            rd(reg_a[i], reg_m[i]);
            wr(reg_a[i], 8'h00);
        end
        pair(4'h1, 1'b0, 20'h00064, 20'h0015E);
        take(4'h1, 1'b0, 20'h000FA);
        pair(4'h1, 1'b0, 20'h001F4, 20'h00064);
        take(4'h1, 1'b0, 20'h00000);
        wr(8'h20, 8'h02);
        model.put(4'h2, 1'b0, 1'b1, 20'h00064);
        model.put(4'h1, 1'b0, 1'b1, 20'h00064);
        model.put(4'h2, 1'b0, 1'b0, 20'h001F4);
        model.put(4'h1, 1'b0, 1'b0, 20'h000C8);
        model.put(4'h2, 1'b0, 1'b1, 20'h000C9);
        take(4'h1, 1'b0, 20'h00064);
        take(4'h2, 1'b0, 20'h0015E);
        repeat (10) @(posedge clk_i);
        chk("extra samples", model.got_q.size(), 0);
        #1 stall = 1'b1;
        for (int k = 1; k <= 4; k++) pair(4'h3, 1'b0, 20'h00000, 20'(k));
        repeat (40) @(posedge clk_i);
        #1;
        chk("conv_ready_o", {31'h0, conv_ready_o}, 0);
        chk("early samples", model.got_q.size(), 0);
        stall = 1'b0;
        for (int k = 1; k <= 4; k++) take(4'h3, 1'b0, 20'(k));
        wr(8'h68, 8'h11);
        wr(8'h6A, 8'h10);
        wr(8'h6C, 8'h10);
        wr(8'h69, 8'h08);
        wr(8'h78, 8'h01);
        for (int k = 0; k < 2; k++) begin
            pair(4'h1, 1'b0, 20'h00000, 20'h20000);
            take(4'h1, 1'b0, 20'h20000);
            rd(8'h00, 8'(k));
        end
        rd(8'h00, 8'h00);
        wr(8'h69, 8'h80);
        wr(8'h7C, 8'h02);
        pair(4'h1, 1'b1, 20'h00000, 20'h20000);
        take(4'h1, 1'b1, 20'h20000);
        rd(8'h00, 8'h02);
        wr(8'h78, 8'h00);
        wr(8'h7C, 8'h00);
        wr(8'h70, 8'h41);
        wr(8'h71, 8'h03);
        pair(4'h1, 1'b0, 20'h00000, 20'h003E8);
        take(4'h1, 1'b0, 20'h003E8);
        pair(4'h1, 1'b1, 20'h00000, 20'h01388);
        take(4'h1, 1'b1, 20'h01388);
        pair(4'h1, 1'b0, 20'h00000, 20'h003F2);
        take(4'h1, 1'b0, 20'h003F2);
        pair(4'h1, 1'b0, 20'h00000, 20'h01388);
        take(4'h1, 1'b0, 20'h003F2);
        wr(8'h70, 8'h44);
        wr(8'h71, 8'h43);
        for (int k = 1; k <= 4; k++) begin
            pair(4'h4, 1'b0, 20'h00000, 20'(k << 8));
            take(4'h4, 1'b0, 20'(k << 8));
        end
        pair(4'h4, 1'b0, 20'h00000, 20'h02000);
        take(4'h4, 1'b0, 20'h00500);
        end_sim();
    end
endmodule

// *** osp_skid_buffer.sv ***
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/10ps
module osp_skid_buffer #(
    parameter int WIDTH = 25,
    parameter int DEPTH = 2
) (
    input  wire logic             clk_i,
    input  wire logic             nrst_i,
    input  wire logic             in_valid_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  in_ready_o,
    output logic                  out_valid_o,
    output logic [WIDTH-1:0]      out_data_o,
    input  wire logic             out_ready_i
);
    logic             spare_valid_reg;
    logic [WIDTH-1:0] spare_data_reg;
    wire              push;
    wire              pop;

    if (DEPTH != 2 || WIDTH < 1) begin : gen_bad_depth
        $error("osp_skid_buffer supports only DEPTH 2");
    end

    assign push = in_valid_i && in_ready_o;
    assign pop  = out_valid_o && out_ready_i;

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            out_valid_o     <= 1'b0;
            out_data_o      <= '0;
            spare_valid_reg <= 1'b0;
            spare_data_reg  <= '0;
            in_ready_o      <= 1'b0;
        end else begin
            if (!out_valid_o || pop) begin
                out_valid_o <= spare_valid_reg || push;
                out_data_o  <= spare_valid_reg ? spare_data_reg : in_data_i;
                if (spare_valid_reg) begin
                    spare_valid_reg <= push;
                    spare_data_reg  <= in_data_i;
                end
            end else if (push) begin
                spare_valid_reg <= 1'b1;
                spare_data_reg  <= in_data_i;
            end
            in_ready_o <= !(spare_valid_reg && !pop) && !(out_valid_o && !pop && push);
        end
    end
endmodule
